//--- rtl/gfcs_pkg.sv
// Purpose: shared types and constants for the glitch-free clock switch
// Assumes: both clock sources are sampled as synchronous inputs on clock
package gfcs_pkg;

    localparam int STALL_CYCLES_DEF = 64;
    localparam logic SEL_A = 1'h0;
    localparam logic SEL_B = 1'h1;
    localparam logic SEL_UNDRIVEN = 1'h1;
    localparam logic OUT_RESET = 1'h0;

    typedef struct packed {
        logic b;
        logic a;
    } gfcs_pair_s;

    typedef enum logic [1:0] {
        GFCS_FOLLOW,
        GFCS_WAIT_OLD_LOW,
        GFCS_WAIT_NEW_LOW
    } gfcs_state_e;

endpackage : gfcs_pkg

//--- rtl/gfcs_activity_mon.sv
// Purpose: flags a clock source that has stopped toggling
// Assumes: src is synchronous to clock
// Notes: a source with no edge for STALL_CYCLES samples counts as lost
`timescale 1ns/1ps
module gfcs_activity_mon #(
    parameter int STALL_CYCLES = gfcs_pkg::STALL_CYCLES_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstSyncN,
    // source and verdict
    input wire logic src,
    output logic lost
);
    localparam int CW = $clog2(STALL_CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(STALL_CYCLES);

    logic prev_ff;
    logic [CW-1:0] count_ff;
    logic lost_ff;
    wire edgeSeen = src != prev_ff;
    wire atLimit = count_ff == LIMIT;
    wire [CW-1:0] nxt_count = edgeSeen ? '0 : (atLimit ? count_ff : count_ff + CW'(1));

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            prev_ff <= 1'h0;
            count_ff <= '0;
            lost_ff <= 1'h0;
        end else begin
            prev_ff <= src;
            count_ff <= nxt_count;
            lost_ff <= !edgeSeen && (nxt_count == LIMIT);
        end
    end

    assign lost = lost_ff;

endmodule : gfcs_activity_mon

//--- rtl/gfcs_switch.sv
// Purpose: two-to-one clock selector with runt suppression and fail-safe hold
// Assumes: sources and select are synchronous to clock; output is a sampled clock
// Notes: a switch parks the output low between the old and new source
`timescale 1ns/1ps
module gfcs_switch #(
    parameter int STALL_CYCLES = gfcs_pkg::STALL_CYCLES_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // clock sources
    input wire gfcs_pkg::gfcs_pair_s clockIn,
    // selection and mode
    input wire logic sourceSelect,
    input wire logic sourceSelectDriven,
    input wire logic resetTimingPinTied,
    // selected clock and status
    output logic clockOut,
    output logic clockOutN,
    output logic activeSource,
    output logic switchPending,
    output logic sourceLost
);
    logic rstMeta_ff;
    logic rstSyncN;
    gfcs_pkg::gfcs_state_e state_ff;
    gfcs_pkg::gfcs_state_e nxt_state;
    logic curSel_ff;
    logic nxt_curSel;
    logic out_ff;
    logic nxt_out;
    logic lostOut_ff;
    gfcs_pkg::gfcs_pair_s lostIn;

    // power-on reset, released through two flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstMeta_ff <= 1'h0;
            rstSyncN <= 1'h0;
        end else begin
            rstMeta_ff <= 1'h1;
            rstSyncN <= rstMeta_ff;
        end
    end

    gfcs_activity_mon #(.STALL_CYCLES(STALL_CYCLES)) u_mon_a (
        .clock(clock),
        .rstSyncN(rstSyncN),
        .src(clockIn.a),
        .lost(lostIn.a)
    );

    gfcs_activity_mon #(.STALL_CYCLES(STALL_CYCLES)) u_mon_b (
        .clock(clock),
        .rstSyncN(rstSyncN),
        .src(clockIn.b),
        .lost(lostIn.b)
    );

    // floating select pulled high
    wire wantSel = sourceSelectDriven ? sourceSelect : gfcs_pkg::SEL_UNDRIVEN;
    // low picks a, high picks b
    wire wantSrc = (wantSel == gfcs_pkg::SEL_B) ? clockIn.b : clockIn.a;
    wire curSrc = (curSel_ff == gfcs_pkg::SEL_B) ? clockIn.b : clockIn.a;
    wire curLost = (curSel_ff == gfcs_pkg::SEL_B) ? lostIn.b : lostIn.a;
    wire wantsSwitch = wantSel != curSel_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_curSel = curSel_ff;
        nxt_out = out_ff;
        if (resetTimingPinTied) begin
            // plain mux: no edge alignment, runts possible by design
            nxt_state = gfcs_pkg::GFCS_FOLLOW;
            nxt_curSel = wantSel;
            nxt_out = wantSrc;
        end else begin
            case (state_ff)
                gfcs_pkg::GFCS_FOLLOW: begin
                    // stuck source: hold rather than track noise
                    nxt_out = curLost ? out_ff : curSrc;
                    if (wantsSwitch) begin
                        nxt_state = gfcs_pkg::GFCS_WAIT_OLD_LOW;
                    end
                end
                gfcs_pkg::GFCS_WAIT_OLD_LOW: begin
                    // finish the old high phase before letting go
                    nxt_out = curSrc;
                    if (!curSrc || curLost) begin
                        nxt_out = 1'h0;
                        nxt_curSel = wantSel;
                        nxt_state = gfcs_pkg::GFCS_WAIT_NEW_LOW;
                    end
                end
                gfcs_pkg::GFCS_WAIT_NEW_LOW: begin
                    // low stretched until the new source is low too
                    nxt_out = 1'h0;
                    if (!curSrc) begin
                        nxt_state = gfcs_pkg::GFCS_FOLLOW;
                    end
                end
                default: begin
                    nxt_state = gfcs_pkg::GFCS_FOLLOW;
                    nxt_out = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_ff <= gfcs_pkg::GFCS_FOLLOW;
            curSel_ff <= gfcs_pkg::SEL_A;
            out_ff <= gfcs_pkg::OUT_RESET;
            lostOut_ff <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            curSel_ff <= nxt_curSel;
            out_ff <= nxt_out;
            lostOut_ff <= curLost;
        end
    end

    logic outN_ff;
    logic pend_ff;
    logic act_ff;
    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            outN_ff <= !gfcs_pkg::OUT_RESET;
            pend_ff <= 1'h0;
            act_ff <= gfcs_pkg::SEL_A;
        end else begin
            outN_ff <= !nxt_out;
            pend_ff <= nxt_state != gfcs_pkg::GFCS_FOLLOW;
            act_ff <= nxt_curSel;
        end
    end

    assign clockOut = out_ff;
    assign clockOutN = outN_ff;
    assign activeSource = act_ff;
    assign switchPending = pend_ff;
    assign sourceLost = lostOut_ff;

    localparam int SWITCH_BOUND = STALL_CYCLES + 4;

    // checks start one edge after release; at that edge the flops still took reset
    logic chkRun_ff;
    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            chkRun_ff <= 1'h0;
        end else begin
            chkRun_ff <= 1'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!chkRun_ff);

    sequence seqSwitchStart;
        state_ff == gfcs_pkg::GFCS_FOLLOW && wantsSwitch && !resetTimingPinTied;
    endsequence

    sequence seqSwitchDone;
        ##[1:SWITCH_BOUND] state_ff == gfcs_pkg::GFCS_WAIT_NEW_LOW || resetTimingPinTied;
    endsequence

    sequence seqNewHigh;
        state_ff == gfcs_pkg::GFCS_WAIT_NEW_LOW && curSrc && !resetTimingPinTied;
    endsequence

    a_switch_bounded: assert property (
        seqSwitchStart |-> seqSwitchDone
    ) else $error("switchover did not leave the old source in time");

    a_bypass_follow: assert property (
        resetTimingPinTied |=> clockOut == $past(wantSrc)
    ) else $error("tied pin did not give plain mux behaviour");

    a_sel_undriven: assert property (
        !sourceSelectDriven && resetTimingPinTied |=> clockOut == $past(clockIn.b)
    ) else $error("undriven select did not choose source b");

    a_sel_low_a: assert property (
        sourceSelectDriven && !sourceSelect && resetTimingPinTied
        |=> clockOut == $past(clockIn.a) && activeSource == gfcs_pkg::SEL_A
    ) else $error("select low did not choose source a");

    a_edge_origin: assert property (
        // a dead old source has no end to its phase, so leaving it drops low
        !resetTimingPinTied && !$past(resetTimingPinTied) && $changed(clockOut)
        |-> clockOut == ($past(curLost) ? 1'h0 : $past(curSrc))
    ) else $error("output edge not taken from the current source");

    a_park_low: assert property (
        state_ff == gfcs_pkg::GFCS_WAIT_NEW_LOW && !$past(resetTimingPinTied) |-> !clockOut
    ) else $error("output not parked low during switchover");

    a_failsafe_hold: assert property (
        state_ff == gfcs_pkg::GFCS_FOLLOW && curLost && !resetTimingPinTied
        && !wantsSwitch |=> $stable(clockOut)
    ) else $error("output moved while selected source was lost");

    a_follow_src: assert property (
        state_ff == gfcs_pkg::GFCS_FOLLOW && !curLost && !resetTimingPinTied
        |=> clockOut == $past(curSrc) && clockOutN == !clockOut
    ) else $error("output does not follow the selected source");

    a_reset_init: assert property (
        $rose(rstSyncN) |-> state_ff == gfcs_pkg::GFCS_FOLLOW && !clockOut && !switchPending
    ) else $error("suppression logic not initialised at reset release");

    a_pending_set: assert property (
        seqSwitchStart |=> switchPending
    ) else $error("switch in progress not flagged");

    a_new_wait: assert property (
        seqNewHigh |=> state_ff == gfcs_pkg::GFCS_WAIT_NEW_LOW && !clockOut
    ) else $error("left the parked state while the new source was high");

    a_lost_leave: assert property (
        state_ff == gfcs_pkg::GFCS_WAIT_OLD_LOW && curLost && !resetTimingPinTied
        |=> state_ff == gfcs_pkg::GFCS_WAIT_NEW_LOW && !clockOut
    ) else $error("switch did not leave a lost source");

    a_lost_flag: assert property (
        curLost |=> sourceLost
    ) else $error("lost source not reported");

endmodule : gfcs_switch

//--- tb/gfcs_source_model.sv
// Purpose: two free-running clock sources feeding the switch
// Assumes: source levels change at the falling edge of clock
// Notes: a stopped source holds its last level, like a clock failed to dc
`timescale 1ns/1ps
module gfcs_source_model #(
    parameter int HALF_A = 3,
    parameter int HALF_B = 2
) (
    // clock
    input wire logic clock,
    // stop controls
    input wire logic stopA,
    input wire logic stopB,
    // sources
    output gfcs_pkg::gfcs_pair_s clockIn
);
    int cntA = 0;
    int cntB = 0;
    initial clockIn = '0;
    always @(negedge clock) begin
        cntA = (cntA + 1) % HALF_A;
        cntB = (cntB + 1) % HALF_B;
        if (!stopA && cntA == 0) clockIn.a <= ~clockIn.a;
        if (!stopB && cntB == 0) clockIn.b <= ~clockIn.b;
    end
endmodule : gfcs_source_model

//--- tb/testbench.sv
// Purpose: self-checking bench for the clock switch
// Assumes: half periods of 3 and 2 cycles, so a phase under 2 is a runt
// Notes: small stall count keeps the lost-source case short
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch %0t %s", $time, msg); end end
module testbench;
    logic clock = 1'h0;
    logic rstn = 1'h0;
    logic sourceSelect = 1'h0;
    logic sourceSelectDriven = 1'h1;
    logic resetTimingPinTied = 1'h1;
    logic stopA = 1'h0;
    logic stopB = 1'h0;
    gfcs_pkg::gfcs_pair_s clockIn;
    logic clockOut, clockOutN, activeSource, switchPending, sourceLost;
    logic lastOut = 1'h0;
    int n_mismatch = 0;
    int checked = 0;
    int runLen = 0;
    // {select, driven, tied, expected source}
    logic [3:0] rows [6] = '{4'h6, 4'hF, 4'h3, 4'h4, 4'hD, 4'h1};

    always #25 clock = ~clock;

    gfcs_source_model gfcs_source_model_inst (.clock(clock), .stopA(stopA), .stopB(stopB),
        .clockIn(clockIn));
    gfcs_switch #(.STALL_CYCLES(8)) gfcs_switch_inst (.clock(clock), .rstn(rstn),
        .clockIn(clockIn), .sourceSelect(sourceSelect),
        .sourceSelectDriven(sourceSelectDriven), .resetTimingPinTied(resetTimingPinTied),
        .clockOut(clockOut), .clockOutN(clockOutN), .activeSource(activeSource),
        .switchPending(switchPending), .sourceLost(sourceLost));

    // phase lengths are judged when they end; tied mode may legally cut them
    always @(negedge clock) begin
        if (clockOut !== lastOut) begin
            if (!resetTimingPinTied && rstn && runLen < 2) `CHK(runLen, 2, "runt")
            runLen = 0;
        end
        runLen++;
        lastOut = clockOut;
    end

    task automatic summarize;
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    task automatic checkReset;
        @(posedge clock);
        #1;
        `CHK({clockOut, clockOutN}, {gfcs_pkg::OUT_RESET, ~gfcs_pkg::OUT_RESET}, "rst out")
        `CHK({activeSource, switchPending, sourceLost}, 3'h0, "rst status")
    endtask : checkReset

    initial begin
        logic hold;
        checkReset();
        repeat (2) @(negedge clock);
        rstn = 1'h1;
        for (int i = 0; i < 6; i++) begin
            @(negedge clock);
            {sourceSelect, sourceSelectDriven, resetTimingPinTied} = rows[i][3:1];
            repeat (20) @(negedge clock);
            for (int k = 0; k < 6; k++) begin
                @(posedge clock);
                #1;
                `CHK(activeSource, rows[i][0], "source")
                `CHK(clockOut, rows[i][0] ? clockIn.b : clockIn.a, "follow")
                `CHK(clockOutN, ~clockOut, "complement")
                `CHK(switchPending, 1'h0, "pending idle")
            end
        end
        // selected source a dies high, then a switch must still leave it
        @(negedge clock);
        {sourceSelect, sourceSelectDriven, resetTimingPinTied} = 3'h2;
        repeat (20) @(negedge clock);
        // stop just after a fresh rise, so the stop cannot race the fall
        for (int k = 0; k < 8 && clockIn.a; k++) @(negedge clock);
        for (int k = 0; k < 8 && !clockIn.a; k++) @(negedge clock);
        `CHK(clockIn.a, 1'h1, "a rise timeout")
        if (clockIn.a !== 1'h1) summarize();
        stopA = 1'h1;
        repeat (12) @(negedge clock);
        `CHK(sourceLost, 1'h1, "lost flag")
        hold = clockOut;
        repeat (8) begin
            @(negedge clock);
            `CHK(clockOut, hold, "hold")
        end
        sourceSelect = 1'h1;
        @(negedge clock);
        `CHK(switchPending, 1'h1, "pending set")
        for (int k = 0; k < 40 && activeSource !== 1'h1; k++) @(negedge clock);
        `CHK(activeSource, 1'h1, "switch timeout")
        `CHK(clockOut, 1'h0, "lost leave")
        if (activeSource !== 1'h1) summarize();
        stopA = 1'h0;
        repeat (10) @(negedge clock);
        rstn = 1'h0;
        checkReset();
        summarize();
    end
endmodule : testbench
